// *** src/cwt_regs.vh ***
`ifndef CWT_REGS_VH
`define CWT_REGS_VH

// byte offsets, decoded on haddr[7:0]
`define CWT_OFF_CTRL    8'h00
`define CWT_OFF_RELOAD  8'h04
`define CWT_OFF_COUNT   8'h08
`define CWT_OFF_STS     8'h0C
`define CWT_OFF_MASK    8'h10

// control register fields
`define CWT_C_PERIODIC_IRQ_ENABLE_FIELD     0
`define CWT_C_RSTEN     1
`define CWT_C_CLKSEL    2
`define CWT_C_PS_LSB    4
`define CWT_C_PS_MSB    7
`define CWT_C_FLAG      8
`define CWT_C_BUSY      9
`define CWT_C_KEY_LSB   16
`define CWT_C_KEY_MSB   31
`define CWT_RESTART_KEY 16'hC3A5

// status and mask fields
`define CWT_S_ZERO      0
`define CWT_S_WDONE     1
`define CWT_S_SRST      2
`define CWT_STS_W       3

// widths and reset values
`define CWT_CNT_W       24
`define CWT_PS_W        4
`define CWT_RELOAD_RST  24'hFFFFFF
`define CWT_COUNT_RST   24'hFFFFFF
`define CWT_PS_RST      4'h0
`define CWT_MASK_RST    3'h0

// soft reset pulse length
`define CWT_CLK_NS      10
`define CWT_SRST_NS     160

`endif

// *** src/cwt_sync2.v ***
`timescale 1ns/1ns
`default_nettype none
module cwt_sync2 (
  input  wire clk,   // sampling clock
  input  wire rst_n, // async reset, active low
  input  wire d,     // asynchronous level
  output wire q      // synchronised level
);
  reg meta_ff;
  reg sync_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule
`default_nettype wire

// *** src/cwt_prescaler.v ***
`timescale 1ns/1ns
`default_nettype none
module cwt_prescaler (
  input  wire       clk,      // bus clock
  input  wire       rst_n,    // async reset, active low
  input  wire       src_tick, // one pulse per source edge
  input  wire [3:0] ps,       // divide by 2^(ps+1)
  output wire       tick      // one pulse per divided period
);
  reg  [15:0] cnt_ff;
  reg         tick_ff;
  wire [15:0] lim;

  // ps 0 gives /2, ps 15 gives /65536
  assign lim = (16'h0002 << ps) - 16'h0001;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (src_tick) begin
        // >= so a smaller ps takes effect without a wrap
        if (cnt_ff >= lim) begin
          cnt_ff  <= 16'h0000;
          tick_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 16'h0001;
        end
      end
    end
  end

  assign tick = tick_ff;
endmodule
`default_nettype wire

// *** src/cwt_timer.v ***
`timescale 1ns/1ns
`default_nettype none
module cwt_timer (
  input  wire        hclk,                // bus clock
  input  wire        hresetn,             // async reset, active low
  input  wire        hsel,                // slave select
  input  wire [31:0] haddr,               // byte address
  input  wire [1:0]  htrans,              // transfer type
  input  wire        hwrite,              // write when high
  input  wire [2:0]  hsize,               // word only
  input  wire [31:0] hwdata,              // write data
  input  wire        hready,              // bus ready
  output wire [31:0] hrdata,              // read data
  output wire        hreadyout,           // slave ready
  output wire        hresp,               // always okay
  input  wire        pll_reference_clock, // source clock 0
  input  wire        pll_output_clock,    // source clock 1
  output wire        countdown_irq,       // countdown flag level
  output wire        irq,                 // masked status level
  output wire        soft_reset           // processor reset pulse
);
`include "cwt_regs.vh"

  // pulse length in bus cycles, rounded up
  localparam integer SRST_CYC_I =
    (`CWT_SRST_NS + `CWT_CLK_NS - 1) / `CWT_CLK_NS;
  localparam [7:0]   SRST_CYC   = SRST_CYC_I[7:0];

  // bus side
  reg  [31:0] hrdata_ff;
  reg         hreadyout_ff;
  reg         hresp_ff;
  reg         dp_wr_ff;
  reg  [7:0]  dp_addr_ff;
  reg  [31:0] rd_mux;
  reg  [31:0] ctrl_rd;
  wire        ap;
  wire        ap_rd;
  wire        sts_rd;
  wire        wr_slow;

  // configuration and state
  reg                   periodic_irq_enable_field_ff;
  reg                   rsten_ff;
  reg                   clksel_ff;
  reg  [`CWT_PS_W-1:0]  ps_ff;
  reg  [`CWT_CNT_W-1:0] reload_ff;
  reg  [`CWT_CNT_W-1:0] count_ff;
  reg                   flag_ff;
  reg                   armed_ff;
  reg  [`CWT_STS_W-1:0] sts_ff;
  reg  [`CWT_STS_W-1:0] mask_ff;
  reg                   irq_ff;
  reg  [7:0]            srst_cnt_ff;
  reg                   soft_reset_ff;

  // pending write held for the divided domain
  reg                   busy_ff;
  reg                   pend_rel_ff;
  reg  [31:0]           pend_data_ff;

  // source clock sampling
  wire ref_s;
  wire out_s;
  reg  ref_d_ff;
  reg  out_d_ff;
  wire src_tick;
  wire tick;

  wire                  commit;
  wire                  key_ok;
  wire                  restart;
  wire                  zero_evt;
  wire                  both_en;
  wire                  flag_set;
  wire                  srst_fire;
  wire                  flag_clr;
  wire [`CWT_STS_W-1:0] sts_set;
  reg  [`CWT_STS_W-1:0] nxt_sts;

  // source pins are foreign to hclk, so two flops first
  cwt_sync2 u_sync_ref (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (pll_reference_clock),
    .q     (ref_s)
  );

  cwt_sync2 u_sync_out (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (pll_output_clock),
    .q     (out_s)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_d_ff <= 1'b0;
      out_d_ff <= 1'b0;
    end else begin
      ref_d_ff <= ref_s;
      out_d_ff <= out_s;
    end
  end

  // switching source may yield one stray edge; harmless for a timer
  assign src_tick = clksel_ff ? (out_s & ~out_d_ff)
                              : (ref_s & ~ref_d_ff);

  // the divider keeps its phase over a restart; first interval may be short
  // hclk must stay up in sleep; counting is paced by the pins only
  cwt_prescaler u_presc (
    .clk      (hclk),
    .rst_n    (hresetn),
    .src_tick (src_tick),
    .ps       (ps_ff),
    .tick     (tick)
  );

  // ahb-lite slave, zero wait states
  assign ap     = hsel & htrans[1] & hready;
  assign ap_rd  = ap & ~hwrite;
  assign sts_rd = ap_rd & (haddr[7:0] == `CWT_OFF_STS);

  // a write in its data phase already counts as pending, so a poll
  // placed right behind it never reads a stale clear bit
  assign wr_slow = dp_wr_ff & ((dp_addr_ff == `CWT_OFF_CTRL) |
                               (dp_addr_ff == `CWT_OFF_RELOAD));

  always @* begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[`CWT_C_PERIODIC_IRQ_ENABLE_FIELD]  = periodic_irq_enable_field_ff;
    ctrl_rd[`CWT_C_RSTEN]  = rsten_ff;
    ctrl_rd[`CWT_C_CLKSEL] = clksel_ff;
    ctrl_rd[`CWT_C_PS_MSB:`CWT_C_PS_LSB] = ps_ff;
    ctrl_rd[`CWT_C_FLAG]   = flag_ff;
    ctrl_rd[`CWT_C_BUSY]   = busy_ff | wr_slow;
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      `CWT_OFF_CTRL:   rd_mux = ctrl_rd;
      `CWT_OFF_RELOAD: rd_mux[`CWT_CNT_W-1:0] = reload_ff;
      `CWT_OFF_COUNT:  rd_mux[`CWT_CNT_W-1:0] = count_ff;
      `CWT_OFF_STS:    rd_mux[`CWT_STS_W-1:0] = sts_ff;
      `CWT_OFF_MASK:   rd_mux[`CWT_STS_W-1:0] = mask_ff;
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      dp_wr_ff     <= 1'b0;
      dp_addr_ff   <= 8'h00;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      dp_wr_ff     <= ap & hwrite;
      if (ap) begin
        dp_addr_ff <= haddr[7:0];
      end
      if (ap_rd) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  // ctrl and reload are written only through the pending slot; mask is written directly
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_ff      <= 1'b0;
      pend_rel_ff  <= 1'b0;
      pend_data_ff <= 32'h0000_0000;
      mask_ff      <= `CWT_MASK_RST;
    end else begin
      if (commit) begin
        busy_ff <= 1'b0;
      end
      if (dp_wr_ff) begin
        case (dp_addr_ff)
          `CWT_OFF_CTRL, `CWT_OFF_RELOAD: begin
            // a write while busy is dropped, software must poll
            if (!busy_ff) begin
              busy_ff      <= 1'b1;
              pend_rel_ff  <= (dp_addr_ff == `CWT_OFF_RELOAD);
              pend_data_ff <= hwdata;
            end
          end
          `CWT_OFF_MASK: mask_ff <= hwdata[`CWT_STS_W-1:0];
          default: ;
        endcase
      end
    end
  end

  assign commit   = tick & busy_ff;
  assign key_ok   = (pend_data_ff[`CWT_C_KEY_MSB:`CWT_C_KEY_LSB] ==
                     `CWT_RESTART_KEY);
  assign restart  = commit & ~pend_rel_ff & key_ok;
  // a clear rides the pending slot, so it lands on the divided tick
  assign flag_clr = commit & ~pend_rel_ff & ~key_ok &
                    pend_data_ff[`CWT_C_FLAG];

  // configuration commit; a key write leaves config untouched
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periodic_irq_enable_field_ff  <= 1'b0;
      rsten_ff  <= 1'b0;
      clksel_ff <= 1'b0;
      ps_ff     <= `CWT_PS_RST;
      reload_ff <= `CWT_RELOAD_RST;
    end else if (commit) begin
      if (pend_rel_ff) begin
        reload_ff <= pend_data_ff[`CWT_CNT_W-1:0];
      end else if (!key_ok) begin
        periodic_irq_enable_field_ff  <= pend_data_ff[`CWT_C_PERIODIC_IRQ_ENABLE_FIELD];
        rsten_ff  <= pend_data_ff[`CWT_C_RSTEN];
        clksel_ff <= pend_data_ff[`CWT_C_CLKSEL];
        ps_ff     <= pend_data_ff[`CWT_C_PS_MSB:`CWT_C_PS_LSB];
      end
    end
  end

  // zero arrival is the tick that moves the count from one to zero
  assign zero_evt  = tick & ~restart &
                     (count_ff == {{(`CWT_CNT_W-1){1'b0}}, 1'b1});
  assign both_en   = periodic_irq_enable_field_ff & rsten_ff;
  assign flag_set  = zero_evt & periodic_irq_enable_field_ff & ~(rsten_ff & armed_ff);
  assign srst_fire = zero_evt & rsten_ff &
                     (~periodic_irq_enable_field_ff | armed_ff);

  // a reload of zero parks the count at zero, never an arrival
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff <= `CWT_COUNT_RST;
    end else if (tick) begin
      if (restart) begin
        count_ff <= reload_ff;
      end else if (count_ff == {`CWT_CNT_W{1'b0}}) begin
        count_ff <= reload_ff;
      end else begin
        count_ff <= count_ff - {{(`CWT_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_ff <= 1'b0;
    end else if (restart | srst_fire | ~both_en) begin
      armed_ff <= 1'b0;
    end else if (zero_evt) begin
      armed_ff <= 1'b1;
    end
  end

  // set wins over a clear landing in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_ff <= 1'b0;
    end else if (flag_set) begin
      flag_ff <= 1'b1;
    end else if (flag_clr) begin
      flag_ff <= 1'b0;
    end
  end

  // both enables low leaves flag_set and srst_fire at zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      srst_cnt_ff <= 8'h00;
    end else if (srst_fire) begin
      srst_cnt_ff <= SRST_CYC;
    end else if (srst_cnt_ff != 8'h00) begin
      srst_cnt_ff <= srst_cnt_ff - 8'h01;
    end
  end

  // a zero arrival inside a running pulse restarts the full length
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_reset_ff <= 1'b0;
    end else begin
      soft_reset_ff <= srst_fire | (srst_cnt_ff > 8'h01);
    end
  end

  assign sts_set = {srst_fire, commit, flag_set};

  always @* begin
    nxt_sts = sts_ff;
    if (sts_rd) begin
      nxt_sts = {`CWT_STS_W{1'b0}};
    end
    nxt_sts = nxt_sts | sts_set;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sts_ff <= {`CWT_STS_W{1'b0}};
    end else begin
      sts_ff <= nxt_sts;
    end
  end

  // taken from the next status so irq rises with the event bit itself
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_sts & mask_ff);
    end
  end

  assign hrdata        = hrdata_ff;
  assign hreadyout     = hreadyout_ff;
  assign hresp         = hresp_ff;
  assign countdown_irq = flag_ff;
  assign irq           = irq_ff;
  assign soft_reset    = soft_reset_ff;
endmodule
`default_nettype wire

// *** testbench/cwt_src_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module cwt_src_model (
  output logic ref_clk, // reference source pin
  output logic out_clk  // output source pin
);
  initial begin
    ref_clk = 1'b0;
    out_clk = 1'b0;
  end
  // oscillators keep going in deep sleep, so neither ever stops
  always #50 ref_clk = ~ref_clk;
  always #30 out_clk = ~out_clk;
endmodule
`default_nettype wire

// *** testbench/cwt_timer_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module cwt_timer_sva (
  input wire        hclk,          // clock
  input wire        hresetn,       // reset
  input wire        hsel,          // select
  input wire [31:0] haddr,         // address
  input wire [1:0]  htrans,        // transfer
  input wire        hwrite,        // write
  input wire [31:0] hwdata,        // wdata
  input wire        hready,        // ready
  input wire [31:0] hrdata,        // rdata
  input wire        hreadyout,     // ready out
  input wire        hresp,         // response
  input wire        countdown_irq, // flag
  input wire        irq,           // status irq
  input wire        soft_reset     // reset pulse
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd_t = hsel && htrans[1] && hready && !hwrite;
  wire wr_t = hsel && htrans[1] && hready && hwrite;
  reg  wctl_ff;
  reg  clr_ff;
  // remembers a clear request until the flag has actually dropped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wctl_ff <= 1'b0;
      clr_ff  <= 1'b0;
    end else begin
      wctl_ff <= wr_t && haddr[7:0] == 8'h00;
      if (wctl_ff && hwdata[8])
        clr_ff <= 1'b1;
      else if (!countdown_irq)
        clr_ff <= 1'b0;
    end
  end
  hready_hi_a: assert property (hreadyout)
    else $error("slave stalled the bus");
  resp_okay_a: assert property (!hresp)
    else $error("error response");
  srst_len_a: assert property ($rose(soft_reset) |->
    soft_reset[*8] ##1 soft_reset[*8] ##1 !soft_reset)
    else $error("soft reset pulse length wrong");
  rdata_hold_a: assert property (!rd_t |=> $stable(hrdata))
    else $error("read data changed without read");
  unmap_zero_a: assert property (rd_t && haddr[7:0] > 8'h10
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  cnt_width_a: assert property (rd_t && (haddr[7:0] == 8'h04 ||
    haddr[7:0] == 8'h08) |=> hrdata[31:24] == 8'h00)
    else $error("count wider than 24 bits");
  sts_clr_a: assert property (rd_t && haddr[7:0] == 8'h0C
    |=> !irq) else $error("status read did not drop irq");
  flag_clr_a: assert property ($fell(countdown_irq) |-> clr_ff)
    else $error("flag dropped without clear");
  cover property ($rose(soft_reset));
  cover property ($rose(countdown_irq));
  cover property ($rose(irq));
endmodule
bind cwt_timer cwt_timer_sva i_sva (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .countdown_irq(countdown_irq),
  .irq(irq), .soft_reset(soft_reset));
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, countdown_irq, irq, soft_reset;
  wire         ref_clk, out_clk;
  wire         hready = hreadyout;
  int          errors, total_checks;
  localparam logic [31:0] KEY = 32'hC3A50000;
  cwt_src_model i_src (.ref_clk(ref_clk), .out_clk(out_clk));
  cwt_timer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pll_reference_clock(ref_clk),
    .pll_output_clock(out_clk), .countdown_irq(countdown_irq),
    .irq(irq), .soft_reset(soft_reset));
  initial hclk = 1'b0;
  always #5 hclk = ~hclk;
  task chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rv = hrdata;
  endtask
  task rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    // slow-domain registers drop writes while one is still pending
    if (a < 8'h08) begin
      rd(8'h00);
      chk("pending set", {31'h0, rv[9]}, 1);
      repeat (300) begin
        if (rv[9] === 1'b0) break;
        rd(8'h00);
      end
      chk("pending clear", {31'h0, rv[9]}, 0);
    end
  endtask
  task nxt(inout logic [31:0] c);
    repeat (100) begin
      rd(8'h08);
      if (rv !== c) break;
    end
    c = rv;
  endtask
  task t_reset;
    logic [7:0]  ofs [6] = '{8'h08, 8'h00, 8'h04, 8'h0C, 8'h10, 8'h14};
    logic [31:0] exp [6] = '{32'hFFFFFF, 0, 32'hFFFFFF, 0, 0, 0};
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i]);
      chk("reset value", rv, exp[i]);
    end
  endtask
  task t_rate(input logic [31:0] cfg, input int per);
    logic [31:0] c, p;
    int t0, n;
    wr(8'h00, cfg);
    rd(8'h08);
    c = rv;
    nxt(c);
    nxt(c);
    t0 = $time;
    p = c;
    nxt(c);
    n = ($time - t0) / 10;
    chk("decrement", c, p - 32'h1);
    chk("tick period", {31'h0, n >= per - 3 && n <= per + 3}, 1);
  endtask
  task t_intv;
    wr(8'h04, 32'h3);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h5);
    wr(8'h00, KEY);
    rd(8'h08);
    chk("restart load", {31'h0, rv <= 32'h3}, 1);
    repeat (1000) if (countdown_irq !== 1'b1) @(posedge hclk);
    chk("flag set", countdown_irq, 1);
    chk("no reset", soft_reset, 0);
    @(posedge hclk);
    chk("irq line", irq, 1);
    rd(8'h0C);
    chk("zero event", rv & 32'h1, 1);
    chk("flag sticky", countdown_irq, 1);
    wr(8'h00, 32'h104);
    chk("flag cleared", countdown_irq, 0);
    repeat (200) @(posedge hclk);
    chk("idle flag", countdown_irq, 0);
    chk("idle reset", soft_reset, 0);
    rd(8'h08);
    chk("auto reload", {31'h0, rv <= 32'h3}, 1);
  endtask
  task t_wdog;
    wr(8'h10, 32'h4);
    wr(8'h00, 32'h6);
    repeat (1000) if (soft_reset !== 1'b1) @(posedge hclk);
    chk("soft reset", soft_reset, 1);
    chk("flag off", countdown_irq, 0);
    repeat (2) @(posedge hclk);
    chk("reset irq", irq, 1);
    rd(8'h0C);
    chk("reset event", rv & 32'h4, 32'h4);
  endtask
  task t_comb;
    logic seen;
    wr(8'h00, 32'h7);
    wr(8'h00, KEY);
    repeat (1000) if (countdown_irq !== 1'b1) @(posedge hclk);
    chk("first zero", {countdown_irq, soft_reset}, 32'h2);
    wr(8'h00, KEY);
    seen = 1'b0;
    // window holds the first zero after restart but not the second
    repeat (60) begin
      @(posedge hclk);
      seen = seen | (soft_reset === 1'b1);
    end
    chk("restart forgets", seen, 0);
    repeat (1000) if (soft_reset !== 1'b1) @(posedge hclk);
    chk("second zero", soft_reset, 1);
  endtask
  task test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_rate(32'h0, 20);
    t_rate(32'h14, 24);
    t_intv;
    t_wdog;
    t_comb;
    test_done;
  end
  initial begin
    #300000;
    errors++;
    test_done;
  end
endmodule
`default_nettype wire
